// ==== adcc_consts.vh ====
/*
  Constants for the converter control block: register offsets, field positions,
  reset values and timing.
  Assumes inclusion by bare name from the design file.
*/
`ifndef ADCC_CONSTS_VH
`define ADCC_CONSTS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define ADCC_OFS_CSR 4'h0
`define ADCC_OFS_DRH 4'h4
`define ADCC_OFS_DRL 4'h8
`define ADCC_OFS_PWR 4'hC

// ----------------------------------------
// Control/status field positions
// ----------------------------------------
`define ADCC_CSR_DONE 7
`define ADCC_CSR_SPEED 6
`define ADCC_CSR_ON 5
`define ADCC_CSR_CH_HI 2
`define ADCC_CSR_CH_LO 0

// ----------------------------------------
// Low register field positions
// ----------------------------------------
`define ADCC_DRL_CAL 4
`define ADCC_DRL_SLOW 3
`define ADCC_DRL_GAIN 2

// ----------------------------------------
// Values and timing
// ----------------------------------------
`define ADCC_RST_BYTE 8'h00
`define ADCC_RST_RES 10'h000
`define ADCC_RES_MAX 10'h3FF
`define ADCC_CH_LAST 3'h6
`define ADCC_GAIN_SHIFT 3
`define ADCC_STEPS 4'hA
`define ADCC_STAB_NS 10000
`define ADCC_CLK_NS 40

`endif

// ==== adcc_conversion_control.v ====
/*
  Control logic of a 10-bit successive-approximation converter with register
  access over Avalon-MM and a digital model of the comparator path.
  Assumes the analog front end presents each selected input as an unsigned
  sample with over and under range flags, all from outside the clock domain.
*/
// The implementer's own choices: the address map and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
`include "adcc_consts.vh"

// How it works
// R1 - Each result is 10 bits, split over a high byte and two low bits.
// R2 - A multiplexer routes one of seven analog inputs to the converter.
// R3 - Software writes the channel select field to choose the input.
// R4 - Setting converter_on powers the converter and starts converting the channel.
// R5 - While converter_on stays set, conversions repeat back to back without a trigger.
// R6 - Each completion sets the done flag and updates both result registers.
// R7 - Reading the high byte or writing control/status clears the done flag.
// R8 - For ten bits software polls, reads the low register, then the high byte.
// R9 - For eight bits software polls, then reads only the high byte.
// R10 - A channel change aborts the conversion, clears the flag, restarts.
// R11 - Inputs above the high reference saturate to all ones without overflow flag.
// R12 - Inputs below the low reference give an all-zero result.
// R13 - gain_stage_select routes the input through a gain of eight.
// R14 - The amplifier is powered by converter_on, so selecting it adds no delay.
// R15 - Clearing converter_on switches everything off and stops conversions.
// R16 - In Wait mode the converter keeps working unchanged.
// R17 - Halt disables the converter; results count only after a stabilization time.
// R18 - Analog use of a pin leaves its logic level readable on the port path.
// R19 - No interrupt is raised; completion is seen only by polling.
// R20 - Channel select holds input n as the binary value of n.
// R21 - High byte holds bits 9 to 2; bits 1 and 0 sit in the low register.
// R22 - Converter clock is cpu/2, cpu when speed, cpu/4 when slow.
module adcc_conversion_control #(
  parameter NUM_CH = 7,
  parameter STAB_CYCLES = (`ADCC_STAB_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS
) (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Avalon-MM slave
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output wire waitrequest,
  // Analog front end, one sample per input
  input wire [NUM_CH*10-1:0] analog_sample,
  input wire [NUM_CH-1:0] above_ref_high,
  input wire [NUM_CH-1:0] below_ref_low,
  // Power modes
  input wire halt_mode,
  input wire wait_mode,
  // Pin levels seen by the port input path
  input wire [NUM_CH-1:0] pin_level,
  output reg [NUM_CH-1:0] port_level,
  // Analog power, calibration and multiplexer controls
  output wire converter_power,
  output wire amp_power,
  output wire amp_calibrate,
  output reg [2:0] mux_select
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam ST_OFF = 2'b00;
  localparam ST_STAB = 2'b01;
  localparam ST_CONV = 2'b10;

  reg [NUM_CH*10-1:0] sample_s1, sample_s2;
  reg [NUM_CH-1:0] above_s1, above_s2, below_s1, below_s2;
  reg halt_s1, halt_s2;
  reg [NUM_CH-1:0] pin_s1;
  reg done_flag, speed, converter_on, cal, slow, gain_stage_select;
  reg [2:0] channel_select;
  reg [7:0] result_high_byte;
  reg [1:0] result_low;
  reg [1:0] state;
  reg [1:0] div_cnt;
  reg [3:0] step;
  reg [9:0] sar;
  reg [15:0] stab_cnt;
  reg ack;
  reg [9:0] sel_sample;
  reg sel_above, sel_below;
  reg [12:0] amp_value;
  reg [9:0] target;
  reg tick;
  wire [9:0] trial;
  wire csr_wr, drh_rd, ch_change, finish;
  wire [31:0] next_readdata;
  integer i;

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  // One wait state on every access keeps read data registered.
  assign waitrequest = (read | write) & ~ack;
  assign csr_wr = write & ack & (address == `ADCC_OFS_CSR);
  assign drh_rd = read & ack & (address == `ADCC_OFS_DRH);
  assign ch_change = csr_wr & (writedata[`ADCC_CSR_CH_HI:`ADCC_CSR_CH_LO] != channel_select);

  // Halt overrides the on bit; Wait has no influence.
  assign converter_power = converter_on & ~halt_s2; // see R15 see R17 see R16
  assign amp_power = converter_power; // see R14
  assign amp_calibrate = cal;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sample_s1 <= {NUM_CH*10{1'b0}};
      sample_s2 <= {NUM_CH*10{1'b0}};
      above_s1 <= {NUM_CH{1'b0}};
      above_s2 <= {NUM_CH{1'b0}};
      below_s1 <= {NUM_CH{1'b0}};
      below_s2 <= {NUM_CH{1'b0}};
      halt_s1 <= 1'b0;
      halt_s2 <= 1'b0;
      pin_s1 <= {NUM_CH{1'b0}};
      port_level <= {NUM_CH{1'b0}};
    end else begin
      sample_s1 <= analog_sample;
      sample_s2 <= sample_s1;
      above_s1 <= above_ref_high;
      above_s2 <= above_s1;
      below_s1 <= below_ref_low;
      below_s2 <= below_s1;
      halt_s1 <= halt_mode;
      halt_s2 <= halt_s1;
      pin_s1 <= pin_level;
      port_level <= pin_s1; // see R18
    end
  end

  // ----------------------------------------
  // Input multiplexer and gain stage
  // ----------------------------------------
  always @* begin
    sel_sample = 10'h000;
    sel_above = 1'b0;
    sel_below = 1'b0;
    for (i = 0; i < NUM_CH; i = i + 1) begin
      if (mux_select == i[2:0]) begin // see R2 see R20
        sel_sample = sample_s2[i*10 +: 10];
        sel_above = above_s2[i];
        sel_below = below_s2[i];
      end
    end
    if (cal) begin
      sel_sample = 10'h000;
      sel_above = 1'b0;
      sel_below = 1'b0;
    end
    amp_value = {3'b000, sel_sample} << `ADCC_GAIN_SHIFT;
    if (sel_below) begin
      target = `ADCC_RST_RES; // see R12
    end else if (sel_above) begin
      target = `ADCC_RES_MAX; // see R11
    end else if (gain_stage_select && (amp_value[12:10] != 3'b000)) begin
      target = `ADCC_RES_MAX; // see R13 see R11
    end else if (gain_stage_select) begin
      target = amp_value[9:0]; // see R13
    end else begin
      target = sel_sample;
    end
  end

  // Converter clock tick: cpu, cpu/2 or cpu/4.
  always @* begin
    if (slow) begin
      tick = (div_cnt == 2'b11); // see R22
    end else if (speed) begin
      tick = 1'b1; // see R22
    end else begin
      tick = div_cnt[0]; // see R22
    end
  end

  assign trial = sar | (10'h200 >> (`ADCC_STEPS - step));
  assign finish = (state == ST_CONV) & tick & (step == 4'h1);

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_OFF;
      div_cnt <= 2'b00;
      step <= 4'h0;
      sar <= `ADCC_RST_RES;
      stab_cnt <= 16'h0000;
      mux_select <= 3'h0;
      result_high_byte <= `ADCC_RST_BYTE;
      result_low <= 2'b00;
    end else begin
      div_cnt <= div_cnt + 2'b01;
      case (state)
        ST_OFF: begin
          if (converter_power) begin
            state <= ST_STAB; // see R4
            stab_cnt <= STAB_CYCLES[15:0];
          end
        end
        ST_STAB: begin
          // No conversion starts after power-up or Halt until the stabilization count has run out.
          if (!converter_power) begin
            state <= ST_OFF;
          end else if (stab_cnt <= 16'h0001) begin
            state <= ST_CONV; // see R17
            step <= `ADCC_STEPS;
            sar <= `ADCC_RST_RES;
            mux_select <= channel_select;
          end else begin
            stab_cnt <= stab_cnt - 16'h0001;
          end
        end
        ST_CONV: begin
          if (!converter_power) begin
            state <= ST_OFF; // see R15
          end else if (ch_change) begin
            step <= `ADCC_STEPS; // see R10
            sar <= `ADCC_RST_RES;
            mux_select <= writedata[`ADCC_CSR_CH_HI:`ADCC_CSR_CH_LO];
          end else if (finish) begin
            result_high_byte <= (trial <= target) ? trial[9:2] : sar[9:2]; // see R6 see R21 see R1
            result_low <= (trial <= target) ? trial[1:0] : sar[1:0]; // see R21
            step <= `ADCC_STEPS; // see R5
            sar <= `ADCC_RST_RES;
            mux_select <= channel_select;
          end else if (tick) begin
            if (trial <= target) begin
              sar <= trial;
            end
            step <= step - 4'h1;
          end
        end
        default: state <= ST_OFF;
      endcase
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done_flag <= 1'b0;
      speed <= 1'b0;
      converter_on <= 1'b0;
      channel_select <= 3'h0;
      cal <= 1'b0;
      slow <= 1'b0;
      gain_stage_select <= 1'b0;
      ack <= 1'b0;
      readdata <= 32'h0000_0000;
    end else begin
      ack <= (read | write) & ~ack;
      // Loading in the wait state lets the data stand at the edge where waitrequest is low.
      if (read & ~ack) begin
        readdata <= next_readdata;
      end
      if (csr_wr) begin
        speed <= writedata[`ADCC_CSR_SPEED];
        converter_on <= writedata[`ADCC_CSR_ON]; // see R4 see R15
        channel_select <= writedata[`ADCC_CSR_CH_HI:`ADCC_CSR_CH_LO]; // see R3
      end
      if (write & ack & (address == `ADCC_OFS_DRL)) begin
        cal <= writedata[`ADCC_DRL_CAL];
        slow <= writedata[`ADCC_DRL_SLOW];
        gain_stage_select <= writedata[`ADCC_DRL_GAIN]; // see R13
      end
      // A completion in the clearing cycle wins, except in the cycle of a channel change.
      if (finish & ~ch_change) begin
        done_flag <= 1'b1; // see R6 see R19
      end else if (csr_wr | drh_rd) begin
        done_flag <= 1'b0; // see R7 see R10
      end
    end
  end

  assign next_readdata =
    (address == `ADCC_OFS_CSR) ? {24'h000000, done_flag, speed, converter_on, 2'b00, channel_select} :
    (address == `ADCC_OFS_DRH) ? {24'h000000, result_high_byte} : // see R8 see R9
    (address == `ADCC_OFS_DRL) ? {24'h000000, 3'b000, cal, slow, gain_stage_select, result_low} :
    (address == `ADCC_OFS_PWR) ? {30'h00000000, state == ST_CONV, converter_power} :
    32'h0000_0000;

endmodule // adcc_conversion_control

`default_nettype wire

// ==== adcc_monitor.sv ====
/* Checker for the converter control block.
   Assumes a bind onto adcc_conversion_control. */
`timescale 1ns/100ps
`default_nettype none
module adcc_monitor #(
  parameter NUM_CH = 7
) (
  // Bus
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Pins and power
  input wire logic halt_mode,
  input wire logic [NUM_CH-1:0] pin_level,
  input wire logic [NUM_CH-1:0] port_level,
  input wire logic converter_power,
  input wire logic amp_power
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire logic rd_done = read && !waitrequest;
  AST_ONE_WAIT: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("wait state longer than one cycle");
  AST_IDLE: assert property (!(read || write) |-> !waitrequest)
    else $error("wait without request");
  AST_AMP_PWR: assert property (amp_power == converter_power)
    else $error("amplifier power differs");
  AST_HALT_OFF: assert property (halt_mode [*4] |-> !converter_power)
    else $error("powered in halt");
  AST_UNMAPPED: assert property (rd_done && address[1:0] != 2'h0 |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_UPPER: assert property (rd_done |-> readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_CSR_RSVD: assert property (rd_done && address == 4'h0 |-> readdata[4:3] == 2'h0)
    else $error("reserved status bits set");
  AST_LOW_RSVD: assert property (rd_done && address == 4'h8 |-> readdata[7:5] == 3'h0)
    else $error("reserved low bits set");
  AST_PORT: assert property ($stable(pin_level) [*5] |-> port_level == pin_level)
    else $error("port path lost pin level");
endmodule // adcc_monitor
bind adcc_conversion_control adcc_monitor #(.NUM_CH(NUM_CH)) u_mon (.clk(clk), .arst_n(arst_n),
  .address(address), .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
  .halt_mode(halt_mode), .pin_level(pin_level), .port_level(port_level),
  .converter_power(converter_power), .amp_power(amp_power));
`default_nettype wire

// ==== adcc_src.sv ====
/* Analog source model for the seven inputs.
   Assumes the bench picks the level mode. */
`timescale 1ns/100ps
`default_nettype none
module adcc_src (
  // Mode: 0 normal, 1 over range, 2 under range
  input wire logic [1:0] mode,
  // Levels seen by the block
  output logic [69:0] analog_sample,
  output logic [6:0] above_ref_high,
  output logic [6:0] below_ref_low,
  output logic [6:0] pin_level
);
  always_comb begin
    for (int n = 0; n < 7; n++) begin
      analog_sample[n*10+:10] = 10'h055 + 10'h07B * n[9:0];
    end
  end
  assign above_ref_high = {7{mode == 2'h1}};
  assign below_ref_low = {7{mode == 2'h2}};
  // Pin levels move with the mode, so a stuck port path shows.
  assign pin_level = 7'h55 ^ {5'h0, mode};
endmodule // adcc_src
`default_nettype wire

// ==== adcc_conversion_control_tb.sv ====
/* Self-checking bench for the converter control block.
   Assumes the analog source model and the checker. */
`timescale 1ns/100ps
`default_nettype none
module adcc_conversion_control_tb;
  logic clk, arst_n, read, write, halt_mode, wait_mode, waitrequest;
  logic converter_power, amp_calibrate;
  logic [1:0] mode;
  logic [2:0] mux_select;
  logic [3:0] address;
  logic [31:0] writedata, readdata, q, lo;
  logic [69:0] analog_sample;
  logic [6:0] above_ref_high, below_ref_low, pin_level, port_level;
  logic [15:0] r;
  int fail_count, check_count;
  // Rows: channel, mode, gain, expected 10-bit result.
  logic [15:0] rows [11] = '{16'h0055, 16'h20D0, 16'h414B, 16'h61C6, 16'h8241, 16'hA2BC,
    16'hC337, 16'h6BFF, 16'hB000, 16'h06A8, 16'h47FF};
  adcc_src u_src (.mode(mode), .analog_sample(analog_sample), .above_ref_high(above_ref_high),
    .below_ref_low(below_ref_low), .pin_level(pin_level));
  // Short stabilization keeps the run brief.
  adcc_conversion_control #(.STAB_CYCLES(2)) DUT (.clk(clk), .arst_n(arst_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .analog_sample(analog_sample), .above_ref_high(above_ref_high),
    .below_ref_low(below_ref_low), .halt_mode(halt_mode), .wait_mode(wait_mode),
    .pin_level(pin_level), .port_level(port_level), .converter_power(converter_power),
    .amp_power(), .amp_calibrate(amp_calibrate), .mux_select(mux_select));
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  task automatic report_and_stop();
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, exp, input string what);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // The request is held until a rising edge samples waitrequest low; data is taken there.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [31:0] v);
    int n;
    @(posedge clk);
    address <= a;
    writedata <= {24'h0, d};
    read <= !wr;
    write <= wr;
    n = 0;
    do begin @(posedge clk); n++; end while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin fail_count++; report_and_stop(); end
    v = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wait_done();
    int k;
    k = 0;
    do begin bus(0, 4'h0, 8'h00, q); k++; end while (q[7] !== 1'b1 && k < 100);
    if (k >= 100) begin fail_count++; report_and_stop(); end
  endtask
  initial begin
    arst_n = 0; read = 0; write = 0; address = 0; writedata = 0;
    halt_mode = 0; wait_mode = 0; mode = 0; fail_count = 0; check_count = 0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    bus(0, 4'h0, 8'h00, q); check(q, 32'h0, "csr reset");
    bus(0, 4'h8, 8'h00, q); check(q[7:2], 6'h0, "low reset");
    for (int i = 0; i < 11; i++) begin
      r = rows[i];
      mode <= r[12:11];
      wait_mode <= i[0];
      bus(1, 4'h0, 8'h00, q);
      bus(1, 4'h8, {5'h0, r[10], 2'h0}, q);
      bus(1, 4'h0, {5'h04, r[15:13]}, q);
      wait_done();
      check(mux_select, r[15:13], "channel");
      bus(0, 4'h8, 8'h00, lo);
      bus(0, 4'h4, 8'h00, q);
      check({q[7:0], lo[1:0]}, r[9:0], "result");
      bus(0, 4'h0, 8'h00, q); check(q[7], 1'b0, "done after read");
      check(port_level, 7'h55 ^ r[12:11], "port level");
    end
    bus(1, 4'h8, 8'h00, q);
    wait_done();
    bus(1, 4'h0, 8'h24, q);
    bus(0, 4'h0, 8'h00, q); check(q[7], 1'b0, "done on change");
    wait_done();
    bus(0, 4'h4, 8'h00, q); check(q[7:0], 8'h90, "new channel");
    wait_done();
    bus(1, 4'h0, 8'h24, q);
    bus(0, 4'h0, 8'h00, q); check(q[7], 1'b0, "done on write");
    halt_mode <= 1'b1;
    repeat (6) @(posedge clk);
    check(converter_power, 1'b0, "halt power");
    halt_mode <= 1'b0;
    repeat (6) @(posedge clk);
    check(converter_power, 1'b1, "wake power");
    bus(1, 4'h0, 8'h00, q);
    @(posedge clk);
    check(converter_power, 1'b0, "off power");
    repeat (60) @(posedge clk);
    bus(0, 4'h0, 8'h00, q); check(q[7], 1'b0, "no conversion off");
    bus(1, 4'h0, 8'hD8, q);
    bus(0, 4'h0, 8'h00, q); check(q, 32'h40, "csr read-only bits");
    bus(0, 4'h2, 8'h00, q); check(q, 32'h0, "unmapped");
    bus(1, 4'h8, 8'h10, q);
    @(posedge clk);
    check(amp_calibrate, 1'b1, "calibrate");
    bus(0, 4'h8, 8'h00, q); check(q[7:2], 6'h04, "low calibrate");
    report_and_stop();
  end
endmodule // adcc_conversion_control_tb
`default_nettype wire
